//--- hw/atacmd_top.sv
// task file and command execution for write verify, recalibrate, seek, init params
`timescale 1ns/1ps
// What this block does
// - 7x decodes seek, 1x decodes recalibrate
// - 91h decodes initialize device parameters
// - 3Ch runs sector write sequence
// - each sector verified right after writing
// - verify reads internally, no host transfer
// - verify errors posted in status and error
// - recalibrate sets busy, then rezero
// - rezero done: status, busy off, interrupt
// - recalibrate accepted in lba mode
// - seek to cylinder and head given
// - seek done: busy off, then interrupt
// - seek complete status always one
// - lba seek translates address to cylinder/head
// - low device/head nibble is max head
// - init params: busy, store, interrupt
// - zero sector count aborts init params
// - geometry survives reset_n, back to default only at power-on
// - init params ignores lba bit
// - lba area stays on default geometry
// - on error only device bit, error valid
module atacmd_top (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       por_n,
  input  wire logic [9:0] hst_addr,
  input  wire logic       hst_wr,
  input  wire logic       hst_rd,
  input  wire logic [7:0] hst_wdata,
  output logic      [7:0] hst_rdata,
  output logic            intrq,
  output logic            drq,
  input  wire logic       buf_full,
  output logic            med_req,
  output logic      [1:0] med_op,
  output logic     [15:0] med_cyl,
  output logic      [3:0] med_head,
  output logic      [7:0] med_sect,
  input  wire logic       med_done,
  input  wire logic       med_err,
  output logic      [7:0] geo_spt,
  output logic      [3:0] geo_max_head
);
  typedef enum logic [5:0] {
    S_IDLE   = 6'b000001,
    S_DATA   = 6'b000010,
    S_XLATE  = 6'b000100,
    S_MEDIA  = 6'b001000,
    S_FINISH = 6'b010000,
    S_IRQ    = 6'b100000
  } atacmd_st_e;

  atacmd_st_e  st, next_st;
  logic        busy, next_busy;
  logic        err, next_err;
  logic [7:0]  error_reg, next_error_reg;
  logic [7:0]  sc, next_sc;
  logic [7:0]  sn, next_sn;
  logic [7:0]  cl, next_cl;
  logic [7:0]  ch, next_ch;
  logic [7:0]  dh, next_dh;
  logic [7:0]  next_rdata;
  logic        next_intrq, next_drq, next_med_req;
  logic [1:0]  next_med_op;
  logic [15:0] next_med_cyl;
  logic [3:0]  next_med_head;
  logic [7:0]  next_med_sect;
  logic [7:0]  next_geo_spt;
  logic [3:0]  next_geo_max_head;
  logic        xl_start, next_xl_start;
  logic [7:0]  status_reg;
  logic        cmd_wr, accept, st_rd;
  logic [27:0] lba_nx;
  atacmd_xl_if xl ();

  atacmd_xlate u_xlate (
    .mclk    (mclk),
    .reset_n (reset_n),
    .xl      (xl)
  );

  assign xl.start = xl_start;
  assign xl.lba = {dh[3:0], ch, cl, sn};

  always_comb begin
    status_reg = 8'h00;
    status_reg[atacmd_pkg::ST_BUSY] = busy;
    status_reg[atacmd_pkg::ST_READY] = 1'b1;
    status_reg[atacmd_pkg::ST_SEEK_DONE] = 1'b1;
    status_reg[atacmd_pkg::ST_DRQ] = drq;
    status_reg[atacmd_pkg::ST_ERR] = err;
  end

  assign cmd_wr = hst_wr && (hst_addr == atacmd_pkg::OFF_COMMAND);
  assign accept = cmd_wr && !busy && (st == S_IDLE || st == S_IRQ);
  assign st_rd = hst_rd && (hst_addr == atacmd_pkg::OFF_COMMAND);
  assign lba_nx = {dh[3:0], ch, cl, sn} + 28'h0000001;

  always_comb begin
    next_st = st;
    next_busy = busy;
    next_err = err;
    next_error_reg = error_reg;
    next_sc = sc;
    next_sn = sn;
    next_cl = cl;
    next_ch = ch;
    next_dh = dh;
    next_drq = drq;
    next_med_req = med_req;
    next_med_op = med_op;
    next_med_cyl = med_cyl;
    next_med_head = med_head;
    next_med_sect = med_sect;
    next_geo_spt = geo_spt;
    next_geo_max_head = geo_max_head;
    next_xl_start = 1'b0;
    // task file writes only while idle
    if (hst_wr && !busy) begin
      unique case (hst_addr)
        atacmd_pkg::OFF_SCOUNT:   next_sc = hst_wdata;
        atacmd_pkg::OFF_SNUMBER:  next_sn = hst_wdata;
        atacmd_pkg::OFF_CYL_LOW:  next_cl = hst_wdata;
        atacmd_pkg::OFF_CYL_HIGH: next_ch = hst_wdata;
        atacmd_pkg::OFF_DEV_HEAD: next_dh = hst_wdata;
        default: ;
      endcase
    end
    unique case (st)
      S_IDLE, S_IRQ: begin
        if (st == S_IRQ) next_st = S_IDLE;
        if (accept) begin
          next_busy = 1'b1;
          next_err = 1'b0;
          next_error_reg = 8'h00;
          if (hst_wdata[7:4] == atacmd_pkg::CMD_RECAL_HI) begin
            // lba bit plays no part here
            next_med_op = atacmd_pkg::MOP_RECAL;
            next_med_cyl = 16'h0000;
            next_med_head = 4'h0;
            next_med_req = 1'b1;
            next_st = S_MEDIA;
          end else if (hst_wdata[7:4] == atacmd_pkg::CMD_SEEK_HI) begin
            next_med_op = atacmd_pkg::MOP_SEEK;
            if (dh[atacmd_pkg::DH_LBA]) begin
              next_xl_start = 1'b1;
              next_st = S_XLATE;
            end else begin
              next_med_cyl = {ch, cl};
              next_med_head = dh[3:0];
              next_med_sect = sn;
              next_med_req = 1'b1;
              next_st = S_MEDIA;
            end
          end else if (hst_wdata == atacmd_pkg::CMD_WRITE_VERIFY) begin
            next_med_op = atacmd_pkg::MOP_WRITE;
            next_drq = 1'b1;
            next_st = S_DATA;
          end else if (hst_wdata == atacmd_pkg::CMD_INIT_PARAMS) begin
            // geometry always taken as chs
            if (sc == 8'h00) begin
              next_err = 1'b1;
              next_error_reg[atacmd_pkg::ER_ABRT] = 1'b1;
            end else begin
              next_geo_spt = sc;
              next_geo_max_head = dh[3:0];
            end
            next_st = S_FINISH;
          end else begin
            next_err = 1'b1;
            next_error_reg[atacmd_pkg::ER_ABRT] = 1'b1;
            next_st = S_FINISH;
          end
        end
      end
      S_DATA: begin
        if (buf_full) begin
          next_drq = 1'b0;
          next_med_op = atacmd_pkg::MOP_WRITE;
          if (dh[atacmd_pkg::DH_LBA]) begin
            next_xl_start = 1'b1;
            next_st = S_XLATE;
          end else begin
            next_med_cyl = {ch, cl};
            next_med_head = dh[3:0];
            next_med_sect = sn;
            next_med_req = 1'b1;
            next_st = S_MEDIA;
          end
        end
      end
      S_XLATE: begin
        // translator works on default geometry only
        if (xl.done) begin
          next_med_cyl = xl.cyl;
          next_med_head = xl.head;
          next_med_sect = xl.sect;
          next_med_req = 1'b1;
          next_st = S_MEDIA;
        end
      end
      S_MEDIA: begin
        if (med_done) begin
          next_med_req = 1'b0;
          if (med_err) begin
            // cause and flag set before busy drops
            next_err = 1'b1; // rest of task file left as it stands
            if (med_op == atacmd_pkg::MOP_WRITE || med_op == atacmd_pkg::MOP_VERIFY) begin
              next_error_reg[atacmd_pkg::ER_UNC] = 1'b1;
            end else begin
              next_error_reg[atacmd_pkg::ER_IDNF] = 1'b1;
            end
            next_st = S_FINISH;
          end else if (med_op == atacmd_pkg::MOP_WRITE) begin
            // internal read-back, drq stays low
            next_med_op = atacmd_pkg::MOP_VERIFY;
            next_med_req = 1'b1;
          end else if (med_op == atacmd_pkg::MOP_VERIFY) begin
            next_sc = sc - 8'h01;
            if (dh[atacmd_pkg::DH_LBA]) begin
              {next_dh[3:0], next_ch, next_cl, next_sn} = lba_nx;
            end else if (sn >= geo_spt) begin
              next_sn = atacmd_pkg::SN_RST;
              if (dh[3:0] >= geo_max_head) begin
                next_dh[3:0] = 4'h0;
                {next_ch, next_cl} = {ch, cl} + 16'h0001;
              end else begin
                next_dh[3:0] = dh[3:0] + 4'h1;
              end
            end else begin
              next_sn = sn + 8'h01;
            end
            if (sc == 8'h01) begin
              next_st = S_FINISH;
            end else begin
              next_drq = 1'b1;
              next_st = S_DATA;
            end
          end else begin
            next_st = S_FINISH;
          end
        end
      end
      S_FINISH: begin
        next_busy = 1'b0;
        next_st = S_IRQ;
      end
    endcase
  end

  always_comb begin
    next_rdata = hst_rdata;
    if (hst_rd) begin
      unique case (hst_addr)
        atacmd_pkg::OFF_ERROR:    next_rdata = error_reg;
        atacmd_pkg::OFF_SCOUNT:   next_rdata = sc;
        atacmd_pkg::OFF_SNUMBER:  next_rdata = sn;
        atacmd_pkg::OFF_CYL_LOW:  next_rdata = cl;
        atacmd_pkg::OFF_CYL_HIGH: next_rdata = ch;
        atacmd_pkg::OFF_DEV_HEAD: next_rdata = dh;
        atacmd_pkg::OFF_COMMAND:  next_rdata = status_reg;
        default:                  next_rdata = 8'h00;
      endcase
    end
    // raise wins over a status read in the same cycle
    next_intrq = (st == S_IRQ) || (intrq && !st_rd && !accept);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= S_IDLE;
      busy <= 1'b0;
      err <= 1'b0;
      error_reg <= atacmd_pkg::TF_RST;
      sc <= atacmd_pkg::TF_RST;
      sn <= atacmd_pkg::SN_RST;
      cl <= atacmd_pkg::TF_RST;
      ch <= atacmd_pkg::TF_RST;
      dh <= atacmd_pkg::TF_RST;
      hst_rdata <= 8'h00;
      intrq <= 1'b0;
      drq <= 1'b0;
      med_req <= 1'b0;
      med_op <= atacmd_pkg::MOP_SEEK;
      med_cyl <= 16'h0000;
      med_head <= 4'h0;
      med_sect <= atacmd_pkg::SN_RST;
      xl_start <= 1'b0;
    end else begin
      st <= next_st;
      busy <= next_busy;
      err <= next_err;
      error_reg <= next_error_reg;
      sc <= next_sc;
      sn <= next_sn;
      cl <= next_cl;
      ch <= next_ch;
      dh <= next_dh;
      hst_rdata <= next_rdata;
      intrq <= next_intrq;
      drq <= next_drq;
      med_req <= next_med_req;
      med_op <= next_med_op;
      med_cyl <= next_med_cyl;
      med_head <= next_med_head;
      med_sect <= next_med_sect;
      xl_start <= next_xl_start;
    end
  end

  // geometry cleared only at power-on, not by reset_n
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      geo_spt <= atacmd_pkg::DEF_SPT;
      geo_max_head <= atacmd_pkg::DEF_MAX_HEAD;
    end else begin
      geo_spt <= next_geo_spt;
      geo_max_head <= next_geo_max_head;
    end
  end

  a_seek_flag_one: assert property (
    @(posedge mclk) disable iff (!reset_n)
    st_rd |=> hst_rdata[atacmd_pkg::ST_SEEK_DONE])
    else $error("seek complete bit read as zero");

  a_irq_after_busy: assert property (
    @(posedge mclk) disable iff (!reset_n)
    $fell(busy) |-> !intrq ##1 intrq)
    else $error("interrupt not raised one cycle after busy fell");

  a_seek_decode: assert property (
    @(posedge mclk) disable iff (!reset_n)
    accept && hst_wdata[7:4] == 4'h7 |=> busy && med_op == atacmd_pkg::MOP_SEEK)
    else $error("seek opcode not decoded");

  a_recal_lba_ok: assert property (
    @(posedge mclk) disable iff (!reset_n)
    accept && hst_wdata[7:4] == 4'h1 |=> busy && med_req && med_cyl == 16'h0000 && !err)
    else $error("recalibrate not started");

  a_init_abort: assert property (
    @(posedge mclk) disable iff (!reset_n)
    accept && hst_wdata == 8'h91 && sc == 8'h00
      |=> err && error_reg[atacmd_pkg::ER_ABRT] ##1 !busy ##1 intrq)
    else $error("zero count init params not aborted");

  a_init_store: assert property (
    @(posedge mclk) disable iff (!reset_n)
    accept && hst_wdata == 8'h91 && sc != 8'h00
      |=> geo_spt == $past(sc) && geo_max_head == $past(dh[3:0]) && !err)
    else $error("geometry not stored");

  a_verify_follows: assert property (
    @(posedge mclk) disable iff (!reset_n)
    st == S_MEDIA && med_op == atacmd_pkg::MOP_WRITE && med_done && !med_err
      |=> st == S_MEDIA && med_op == atacmd_pkg::MOP_VERIFY && med_req)
    else $error("verify did not follow sector write");

  a_verify_no_drq: assert property (
    @(posedge mclk) disable iff (!reset_n)
    med_op == atacmd_pkg::MOP_VERIFY && med_req |-> !drq)
    else $error("host transfer requested during verify");

  a_err_before_irq: assert property (
    @(posedge mclk) disable iff (!reset_n)
    $rose(intrq) && err |-> error_reg != 8'h00 && $past(err))
    else $error("error flag without cause before interrupt");

  a_lba_seek_xlate: assert property (
    @(posedge mclk) disable iff (!reset_n)
    accept && hst_wdata[7:4] == 4'h7 && dh[atacmd_pkg::DH_LBA] |=> st == S_XLATE ##[1:60] med_req)
    else $error("lba seek not translated");
endmodule // atacmd_top

//--- hw/atacmd_pkg.sv
// constants shared by the ata command execution block
package atacmd_pkg;
  localparam int         ADDR_W       = 10;
  localparam int         LBA_W        = 28;
  // task file offsets
  localparam logic [9:0] OFF_ERROR    = 10'h1f1;
  localparam logic [9:0] OFF_SCOUNT   = 10'h1f2;
  localparam logic [9:0] OFF_SNUMBER  = 10'h1f3;
  localparam logic [9:0] OFF_CYL_LOW  = 10'h1f4;
  localparam logic [9:0] OFF_CYL_HIGH = 10'h1f5;
  localparam logic [9:0] OFF_DEV_HEAD = 10'h1f6;
  localparam logic [9:0] OFF_COMMAND  = 10'h1f7;
  // command codes
  localparam logic [7:0] CMD_WRITE_VERIFY = 8'h3c;
  localparam logic [7:0] CMD_INIT_PARAMS  = 8'h91;
  localparam logic [3:0] CMD_SEEK_HI      = 4'h7;
  localparam logic [3:0] CMD_RECAL_HI     = 4'h1;
  // status bit positions
  localparam int         ST_BUSY      = 7;
  localparam int         ST_READY     = 6;
  localparam int         ST_SEEK_DONE = 4;
  localparam int         ST_DRQ       = 3;
  localparam int         ST_ERR       = 0;
  // error bit positions
  localparam int         ER_UNC       = 6;
  localparam int         ER_IDNF      = 4;
  localparam int         ER_ABRT      = 2;
  // device/head bit positions
  localparam int         DH_LBA       = 6;
  // reset values
  localparam logic [7:0] TF_RST       = 8'h00;
  localparam logic [7:0] SN_RST       = 8'h01;
  // default geometry, also used for all lba translation
  localparam logic [7:0] DEF_SPT      = 8'h3f;
  localparam logic [3:0] DEF_MAX_HEAD = 4'hf;
  localparam logic [4:0] XL_LAST_STEP = 5'h1b;
  // media operations
  localparam logic [1:0] MOP_SEEK     = 2'h0;
  localparam logic [1:0] MOP_RECAL    = 2'h1;
  localparam logic [1:0] MOP_WRITE    = 2'h2;
  localparam logic [1:0] MOP_VERIFY   = 2'h3;
endpackage

//--- hw/atacmd_xl_if.sv
// lba to cylinder/head/sector translation handshake
`timescale 1ns/1ps
interface atacmd_xl_if;
  logic        start;
  logic [27:0] lba;
  logic        done;
  logic [15:0] cyl;
  logic [3:0]  head;
  logic [7:0]  sect;
  modport req (output start, output lba, input done, input cyl, input head, input sect);
  modport srv (input start, input lba, output done, output cyl, output head, output sect);
endinterface

//--- hw/atacmd_xlate.sv
// bit-serial lba to cylinder/head/sector translator on default geometry
`timescale 1ns/1ps
module atacmd_xlate (
  input wire logic   mclk,
  input wire logic   reset_n,
  atacmd_xl_if.srv   xl
);
  typedef enum logic [2:0] {
    X_IDLE = 3'b001,
    X_SPT  = 3'b010,
    X_HEAD = 3'b100
  } atacmd_xst_e;

  atacmd_xst_e st, next_st;
  logic [27:0] num, next_num;
  logic [7:0]  rem, next_rem;
  logic [4:0]  cnt, next_cnt;
  logic        done, next_done;
  logic [15:0] cyl, next_cyl;
  logic [3:0]  head, next_head;
  logic [7:0]  sect, next_sect;
  logic [8:0]  rem_sh, dv, rem_nx;
  logic        ge;

  always_comb begin
    rem_sh = {rem, num[27]};
    dv = (st == X_SPT) ? {1'b0, atacmd_pkg::DEF_SPT}
                       : {5'h00, atacmd_pkg::DEF_MAX_HEAD} + 9'h001;
    ge = (rem_sh >= dv);
    rem_nx = ge ? rem_sh - dv : rem_sh;
    next_st = st;
    next_num = num;
    next_rem = rem;
    next_cnt = cnt;
    next_done = 1'b0;
    next_cyl = cyl;
    next_head = head;
    next_sect = sect;
    unique case (st)
      X_IDLE: begin
        if (xl.start) begin
          next_num = xl.lba;
          next_rem = 8'h00;
          next_cnt = 5'h00;
          next_st = X_SPT;
        end
      end
      X_SPT, X_HEAD: begin
        // one restoring division step per cycle
        next_num = {num[26:0], ge};
        next_rem = rem_nx[7:0];
        next_cnt = cnt + 5'h01;
        if (cnt == atacmd_pkg::XL_LAST_STEP) begin
          next_cnt = 5'h00;
          next_rem = 8'h00;
          if (st == X_SPT) begin
            next_sect = rem_nx[7:0] + 8'h01;
            next_st = X_HEAD;
          end else begin
            next_cyl = next_num[15:0];
            next_head = rem_nx[3:0];
            next_done = 1'b1;
            next_st = X_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= X_IDLE;
      num <= 28'h0000000;
      rem <= 8'h00;
      cnt <= 5'h00;
      done <= 1'b0;
      cyl <= 16'h0000;
      head <= 4'h0;
      sect <= 8'h01;
    end else begin
      st <= next_st;
      num <= next_num;
      rem <= next_rem;
      cnt <= next_cnt;
      done <= next_done;
      cyl <= next_cyl;
      head <= next_head;
      sect <= next_sect;
    end
  end

  assign xl.done = done;
  assign xl.cyl = cyl;
  assign xl.head = head;
  assign xl.sect = sect;
endmodule // atacmd_xlate

//--- tb/atacmd_media_model.sv
// media and sector buffer stand-in answering the command block's requests
`timescale 1ns/1ps
module atacmd_media_model (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       med_req,
  input  wire logic [1:0] med_op,
  input  wire logic       drq,
  input  wire logic [3:0] lat,
  input  wire logic [2:0] fail_op,
  output logic            med_done,
  output logic            med_err,
  output logic            buf_full
);
  logic [3:0] cnt;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt      <= 4'h0;
      med_done <= 1'b0;
      med_err  <= 1'b0;
      buf_full <= 1'b0;
    end else begin
      // one sector lands a cycle after drq, then is taken
      buf_full <= drq & ~buf_full;
      med_done <= 1'b0;
      // error line means nothing outside the done pulse
      med_err  <= ~med_err;
      if (med_done || !med_req) begin
        cnt <= 4'h0;
      end else if (cnt == lat) begin
        med_done <= 1'b1;
        med_err  <= fail_op[2] && (fail_op[1:0] == med_op);
        cnt      <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // atacmd_media_model

//--- tb/testbench.sv
// self-checking bench for the ata command execution block
`timescale 1ns/1ps
module testbench;
  logic        mclk, reset_n, por_n, hst_wr, hst_rd, intrq, drq, buf_full;
  logic        med_req, med_done, med_err;
  logic [9:0]  hst_addr;
  logic [7:0]  hst_wdata, hst_rdata, med_sect, geo_spt, v;
  logic [1:0]  med_op;
  logic [15:0] med_cyl;
  logic [3:0]  med_head, geo_max_head, lat;
  logic [2:0]  fail_op;
  logic [14:0] log_q[$];
  int          err_total = 0;
  int          n_compared = 0;

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  atacmd_top uut (.mclk(mclk), .reset_n(reset_n), .por_n(por_n), .hst_addr(hst_addr),
    .hst_wr(hst_wr), .hst_rd(hst_rd), .hst_wdata(hst_wdata), .hst_rdata(hst_rdata),
    .intrq(intrq), .drq(drq), .buf_full(buf_full), .med_req(med_req), .med_op(med_op),
    .med_cyl(med_cyl), .med_head(med_head), .med_sect(med_sect), .med_done(med_done),
    .med_err(med_err), .geo_spt(geo_spt), .geo_max_head(geo_max_head));

  atacmd_media_model media (.mclk(mclk), .reset_n(reset_n), .med_req(med_req),
    .med_op(med_op), .drq(drq), .lat(lat), .fail_op(fail_op), .med_done(med_done),
    .med_err(med_err), .buf_full(buf_full));

  always @(posedge mclk) if (med_done === 1'b1) log_q.push_back({drq, med_op, med_head, med_sect});

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    hst_addr = a;
    hst_wdata = d;
    hst_wr = 1'b1;
    @(posedge mclk);
    #1;
    hst_wr = 1'b0;
  endtask

  task automatic rd(input logic [9:0] a);
    @(posedge mclk);
    #1;
    hst_addr = a;
    hst_rd = 1'b1;
    @(posedge mclk);
    #1;
    hst_rd = 1'b0;
    v = hst_rdata;
  endtask

  task automatic wait_sig(input logic which);
    int k;
    for (k = 0; k < 400; k++) begin
      if ((which ? med_req : intrq) === 1'b1) break;
      @(posedge mclk);
      #1;
    end
    if (k == 400) chk(1'b0, 1'b1);
  endtask

  task automatic finish(input logic [7:0] e_st, e_er);
    wait_sig(1'b0);
    rd(10'h1f7);
    chk(v, e_st);
    chk(intrq, 1'b0);
    rd(10'h1f1);
    chk(v, e_er);
  endtask

  task automatic do_cmd(input logic [7:0] cmd, dh, input logic [1:0] e_op,
                        input logic [15:0] e_cyl, input logic [3:0] e_hd,
                        input logic [7:0] e_st, e_er);
    wr(10'h1f6, dh);
    wr(10'h1f7, cmd);
    rd(10'h1f7);
    chk(v[7], 1'b1);
    wait_sig(1'b1);
    chk(med_op, e_op);
    chk(med_cyl, e_cyl);
    chk(med_head, e_hd);
    finish(e_st, e_er);
  endtask

  task automatic t_reset_vals();
    logic [7:0] e[8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h50};
    for (int i = 0; i < 8; i++) begin
      rd(10'h1f0 + 10'(i));
      chk(v, e[i]);
    end
    chk(geo_spt, atacmd_pkg::DEF_SPT);
    chk(geo_max_head, atacmd_pkg::DEF_MAX_HEAD);
  endtask

  task automatic t_codes();
    wr(10'h1f4, 8'h34);
    wr(10'h1f5, 8'h12);
    for (int i = 0; i < 4; i++) begin
      lat = 4'(i * 4 + 2);
      if (i < 2) do_cmd({4'h7, 4'(i * 15)}, 8'h05, 2'h0, 16'h1234, 4'h5, 8'h50, 8'h00);
      else do_cmd({4'h1, 4'(i * 15)}, 8'h4c, 2'h1, 16'h0000, 4'h0, 8'h50, 8'h00);
    end
  endtask

  task automatic t_lba_seek();
    int lba = 1000;
    int spt = int'(atacmd_pkg::DEF_SPT);
    int nh = int'(atacmd_pkg::DEF_MAX_HEAD) + 1;
    log_q.delete();
    wr(10'h1f3, 8'he8);
    wr(10'h1f4, 8'h03);
    wr(10'h1f5, 8'h00);
    do_cmd(8'h75, 8'h40, 2'h0, 16'(lba / (spt * nh)), 4'(lba / spt % nh), 8'h50, 8'h00);
    chk(log_q[0][7:0], 8'(lba % spt + 1));
  endtask

  task automatic t_init();
    wr(10'h1f2, 8'h20);
    wr(10'h1f6, 8'h4a);
    wr(10'h1f7, 8'h91);
    finish(8'h50, 8'h00);
    chk(geo_spt, 8'h20);
    chk(geo_max_head, 4'ha);
    reset_n = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    chk(geo_spt, 8'h20);
    chk(geo_max_head, 4'ha);
    wr(10'h1f2, 8'h00);
    wr(10'h1f7, 8'h91);
    finish(8'h51, 8'h04);
    chk(geo_spt, 8'h20);
    // lba reach judged on default geometry, never on the one just set
    wr(10'h1f3, 8'he8);
    wr(10'h1f4, 8'h03);
    do_cmd(8'h70, 8'h40, 2'h0, 16'h0000, 4'hf, 8'h50, 8'h00);
  endtask

  task automatic t_wverify();
    logic [14:0] ex[4] = '{{3'h2, 4'h3, 8'h20}, {3'h3, 4'h3, 8'h20},
                           {3'h2, 4'h4, 8'h01}, {3'h3, 4'h4, 8'h01}};
    lat = 4'h0;
    log_q.delete();
    wr(10'h1f2, 8'h02);
    wr(10'h1f3, 8'h20);
    wr(10'h1f4, 8'h10);
    wr(10'h1f6, 8'h03);
    wr(10'h1f7, 8'h3c);
    finish(8'h50, 8'h00);
    chk(16'(log_q.size()), 16'h0004);
    foreach (ex[i]) chk(log_q[i], ex[i]);
    rd(10'h1f2);
    chk(v, 8'h00);
    // one lba sector from 0x1002: sector 4, head 1 on default geometry
    log_q.delete();
    wr(10'h1f2, 8'h01);
    wr(10'h1f6, 8'h40);
    wr(10'h1f7, 8'h3c);
    finish(8'h50, 8'h00);
    chk(16'(log_q.size()), 16'h0002);
    chk(log_q[0], {3'h2, 4'h1, 8'h04});
    chk(log_q[1], {3'h3, 4'h1, 8'h04});
    rd(10'h1f3);
    chk(v, 8'h03);
  endtask

  task automatic t_errors();
    fail_op = 3'h7;
    wr(10'h1f2, 8'h01);
    wr(10'h1f7, 8'h3c);
    finish(8'h51, 8'h40);
    // undecoded opcode ends in abort
    wr(10'h1f7, 8'h50);
    finish(8'h51, 8'h04);
    fail_op = 3'h5;
    lat = 4'h3;
    do_cmd(8'h10, 8'h00, 2'h1, 16'h0000, 4'h0, 8'h51, 8'h10);
    fail_op = 3'h0;
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #500000;
    err_total++;
    report_and_stop();
  end

  initial begin
    reset_n = 1'b0;
    por_n = 1'b0;
    hst_wr = 1'b0;
    hst_rd = 1'b0;
    hst_addr = 10'h000;
    hst_wdata = 8'h00;
    lat = 4'h2;
    fail_op = 3'h0;
    repeat (3) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    por_n = 1'b1;
    t_reset_vals();
    t_codes();
    t_lba_seek();
    t_init();
    t_wverify();
    t_errors();
    report_and_stop();
  end
endmodule // testbench
